// ### rtl/probe_latch_pkg.sv
package probe_latch_pkg;

	// ==========================================================
	// register map (byte addresses on the word bus)
	localparam logic [15:0] STATUS_OFS = 16'h35F4;
	localparam logic [15:0] CONTROL_OFS = 16'h35F0;
	localparam logic [15:0] C1_RISE_POS_OFS = 16'h3600;
	localparam logic [15:0] C1_FALL_POS_OFS = 16'h3604;
	localparam logic [15:0] C2_RISE_POS_OFS = 16'h3608;
	localparam logic [15:0] C2_FALL_POS_OFS = 16'h360C;
	localparam logic [15:0] C1_RISE_CNT_OFS = 16'h3610;
	localparam logic [15:0] C1_FALL_CNT_OFS = 16'h3614;
	localparam logic [15:0] C2_RISE_CNT_OFS = 16'h3618;
	localparam logic [15:0] C2_FALL_CNT_OFS = 16'h361C;
	localparam logic [15:0] DI_SEL_OFS = 16'h3620;
	localparam logic [15:0] IRQ_STAT_OFS = 16'h3624;
	localparam logic [15:0] IRQ_MASK_OFS = 16'h3628;

	// ==========================================================
	// field layout
	localparam int CH2_BASE = 8;
	localparam int F_ENABLE = 0;
	localparam int F_MODE = 1;
	localparam int F_SOURCE = 2;
	localparam int F_RISE_EN = 4;
	localparam int F_FALL_EN = 5;
	localparam int S_RISE_HELD = 1;
	localparam int S_FALL_HELD = 2;
	localparam int S_COUNT = 6;
	localparam logic [15:0] CONTROL_RST = 16'h0000;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] CONTROL_MASK = 16'h3737;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_t;

	typedef struct packed {
		logic enable;
		logic mode;
		logic source;
		logic rise_en;
		logic fall_en;
	} chan_cfg_t;

	typedef struct packed {
		logic [15:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} av_req_t;

endpackage : probe_latch_pkg

// ### rtl/dual_touch_probe_latch.sv
`timescale 1ns/1ns

module dual_touch_probe_latch
	import probe_latch_pkg::*;
#(
	parameter int DI_COUNT = 5,
	parameter int DI_SEL_W = 3,
	parameter int TURN_W = 26
) (
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic [15:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic [DI_COUNT-1:0] DIGITAL_INPUT_LINE_I,
	input wire logic ABS_ENCODER_I,
	input wire logic INDEX_PULSE_I,
	input wire logic [TURN_W-1:0] TURN_POSITION_I,
	input wire logic signed [31:0] POSITION_I,
	output logic IRQ_O
);

	// ==========================================================
	// helpers
	function automatic chan_cfg_t cfg_of(input logic [15:0] w, input int b);
		chan_cfg_t c;
		c.enable = w[b + F_ENABLE];
		c.mode = w[b + F_MODE];
		c.source = w[b + F_SOURCE];
		c.rise_en = w[b + F_RISE_EN];
		c.fall_en = w[b + F_FALL_EN];
		return c;
	endfunction : cfg_of

	function automatic logic di_pick(input logic [DI_COUNT-1:0] v,
		input logic [DI_SEL_W-1:0] s);
		logic r;
		r = 1'b0;
		for (int i = 0; i < DI_COUNT; i++) begin
			if (s == DI_SEL_W'(i)) begin
				r = v[i];
			end
		end
		return r;
	endfunction : di_pick

	// ==========================================================
	// registers
	logic [15:0] probe_control_object;
	logic [DI_SEL_W-1:0] di_sel [2];
	logic trig_prev [2];
	logic armed_prev [2];
	logic rise_held [2];
	logic fall_held [2];
	logic [1:0] evt_count [2];
	logic signed [31:0] rise_pos [2];
	logic signed [31:0] fall_pos [2];
	logic [15:0] rise_cnt [2];
	logic [15:0] fall_cnt [2];
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	bus_state_t bus_state;
	av_req_t req;

	assign req.address = AVS_ADDRESS_I;
	assign req.read = AVS_READ_I;
	assign req.write = AVS_WRITE_I;
	assign req.writedata = AVS_WRITEDATA_I;

	// ==========================================================
	// index pulse source
	logic turn_zero;
	logic index_src;
	assign turn_zero = (TURN_POSITION_I == '0);
	assign index_src = ABS_ENCODER_I ? turn_zero : INDEX_PULSE_I;

	// ==========================================================
	// capture channels
	chan_cfg_t cfg [2];
	logic trig [2];
	logic rise_ev [2];
	logic fall_ev [2];
	logic rearm [2];
	logic rise_take [2];
	logic fall_take [2];
	logic [1:0] evt_base [2];
	logic [15:0] status_word;

	for (genvar c = 0; c < 2; c++) begin : g_chan
		assign cfg[c] = cfg_of(probe_control_object, c * CH2_BASE);
		assign trig[c] = cfg[c].source ? index_src
			: di_pick(DIGITAL_INPUT_LINE_I, di_sel[c]);
		assign rise_ev[c] = cfg[c].enable && trig[c] && !trig_prev[c];
		assign fall_ev[c] = cfg[c].enable && !trig[c] && trig_prev[c];
		assign rearm[c] = cfg[c].enable && !armed_prev[c];
		// single mode latches an edge only while not yet held, or in the re-enable cycle
		assign rise_take[c] = rise_ev[c] && cfg[c].rise_en
			&& (cfg[c].mode || rearm[c] || !rise_held[c]);
		assign fall_take[c] = fall_ev[c] && cfg[c].fall_en
			&& (cfg[c].mode || rearm[c] || !fall_held[c]);
		// a latch in the re-enable cycle counts from zero
		assign evt_base[c] = rearm[c] ? 2'h0 : evt_count[c];

		always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
			if (SYS_RST_I) begin
				trig_prev[c] <= 1'b0;
				armed_prev[c] <= 1'b0;
				rise_held[c] <= 1'b0;
				fall_held[c] <= 1'b0;
				evt_count[c] <= 2'h0;
				rise_pos[c] <= 32'sh0000_0000;
				fall_pos[c] <= 32'sh0000_0000;
				rise_cnt[c] <= 16'h0000;
				fall_cnt[c] <= 16'h0000;
			end else begin
				trig_prev[c] <= trig[c];
				armed_prev[c] <= cfg[c].enable;
				if (rearm[c]) begin
					rise_held[c] <= 1'b0;
					fall_held[c] <= 1'b0;
					evt_count[c] <= 2'h0;
				end
				if (rise_take[c]) begin
					rise_held[c] <= 1'b1;
					rise_pos[c] <= POSITION_I;
					rise_cnt[c] <= rise_cnt[c] + 16'h0001;
				end
				if (fall_take[c]) begin
					fall_held[c] <= 1'b1;
					fall_pos[c] <= POSITION_I;
					fall_cnt[c] <= fall_cnt[c] + 16'h0001;
				end
				if (cfg[c].mode && (rise_take[c] || fall_take[c])) begin
					evt_count[c] <= evt_base[c] + 2'h1;
				end
			end
		end
	end

	assign status_word = {evt_count[1], 3'b000, fall_held[1],
		rise_held[1], cfg[1].enable,
		evt_count[0], 3'b000, fall_held[0],
		rise_held[0], cfg[0].enable};

	// ==========================================================
	// register bus
	logic acc;
	logic acc_wr;
	logic wr_ctrl;
	logic wr_sel;
	logic wr_mask;
	logic rd_irq;
	logic [31:0] rd_mux;
	logic [3:0] irq_ev;
	logic [3:0] next_irq_stat;
	logic sel_lock0;
	logic sel_lock1;

	assign acc = req.read && bus_state == BUS_IDLE;
	// writes land at the edge where the master sees waitrequest low
	assign acc_wr = req.write && bus_state == BUS_ANSWER;
	assign wr_ctrl = acc_wr && req.address == CONTROL_OFS;
	assign wr_sel = acc_wr && req.address == DI_SEL_OFS;
	assign wr_mask = acc_wr && req.address == IRQ_MASK_OFS;
	assign rd_irq = acc && req.address == IRQ_STAT_OFS;
	// selection frozen while an input-sourced channel is enabled
	assign sel_lock0 = cfg[0].enable && !cfg[0].source;
	assign sel_lock1 = cfg[1].enable && !cfg[1].source;
	assign irq_ev = {fall_take[1], rise_take[1], fall_take[0], rise_take[0]};
	assign next_irq_stat = (rd_irq ? 4'h0 : irq_stat) | irq_ev;

	always_comb begin
		case (req.address)
			STATUS_OFS: rd_mux = {16'h0000, status_word};
			CONTROL_OFS: rd_mux = {16'h0000, probe_control_object};
			C1_RISE_POS_OFS: rd_mux = rise_pos[0];
			C1_FALL_POS_OFS: rd_mux = fall_pos[0];
			C2_RISE_POS_OFS: rd_mux = rise_pos[1];
			C2_FALL_POS_OFS: rd_mux = fall_pos[1];
			C1_RISE_CNT_OFS: rd_mux = {16'h0000, rise_cnt[0]};
			C1_FALL_CNT_OFS: rd_mux = {16'h0000, fall_cnt[0]};
			C2_RISE_CNT_OFS: rd_mux = {16'h0000, rise_cnt[1]};
			C2_FALL_CNT_OFS: rd_mux = {16'h0000, fall_cnt[1]};
			DI_SEL_OFS: rd_mux = {16'h0000, 8'(di_sel[1]), 8'(di_sel[0])};
			IRQ_STAT_OFS: rd_mux = {28'h0000000, irq_stat};
			IRQ_MASK_OFS: rd_mux = {28'h0000000, irq_mask};
			default: rd_mux = UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			bus_state <= BUS_IDLE;
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O <= 32'h0000_0000;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if (req.read || req.write) begin
						bus_state <= BUS_ANSWER;
						AVS_WAITREQUEST_O <= 1'b0;
						AVS_READDATA_O <= req.read ? rd_mux : 32'h0000_0000;
					end
				end
				BUS_ANSWER: begin
					bus_state <= BUS_IDLE;
					AVS_WAITREQUEST_O <= 1'b1;
				end
				default: bus_state <= BUS_IDLE;
			endcase
		end
	end

	// status word has no write path
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			probe_control_object <= CONTROL_RST;
			di_sel[0] <= '0;
			di_sel[1] <= '0;
			irq_mask <= 4'h0;
			irq_stat <= 4'h0;
			IRQ_O <= 1'b0;
		end else begin
			if (wr_ctrl && AVS_BYTEENABLE_I[0]) begin
				probe_control_object[7:0] <= req.writedata[7:0] & CONTROL_MASK[7:0];
			end
			if (wr_ctrl && AVS_BYTEENABLE_I[1]) begin
				probe_control_object[15:8] <=
					req.writedata[15:8] & CONTROL_MASK[15:8];
			end
			if (wr_sel && AVS_BYTEENABLE_I[0] && !sel_lock0) begin
				di_sel[0] <= req.writedata[DI_SEL_W-1:0];
			end
			if (wr_sel && AVS_BYTEENABLE_I[1] && !sel_lock1) begin
				di_sel[1] <= req.writedata[8 +: DI_SEL_W];
			end
			if (wr_mask && AVS_BYTEENABLE_I[0]) begin
				irq_mask <= req.writedata[3:0];
			end
			irq_stat <= next_irq_stat;
			IRQ_O <= |(next_irq_stat & irq_mask);
		end
	end

	// ==========================================================
	// checks
	a_status_bit_enable: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I) status_word[0] == probe_control_object[0])
		else $error("status enable mismatch");
	a_rise_sets_held: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I) rise_take[0] |=> status_word[S_RISE_HELD])
		else $error("rise flag not set");
	a_fall_sets_held: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I) fall_take[0] |=> status_word[S_FALL_HELD])
		else $error("fall flag not set");
	a_rise_pos_stored: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		rise_take[0] |=> rise_pos[0] == $past(POSITION_I))
		else $error("rise position not stored");
	a_rise_counter_step: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		rise_take[1] |=> rise_cnt[1] == $past(rise_cnt[1]) + 16'h0001)
		else $error("counter did not step");
	a_single_once: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		!cfg[0].mode && rise_held[0] && !rearm[0] |=> $stable(rise_pos[0]))
		else $error("single mode relatched");
	a_sel_locked: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		sel_lock0 && $past(sel_lock0) |-> $stable(di_sel[0]))
		else $error("input selection changed");
	a_single_no_count: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		!cfg[0].mode && !rearm[0] |=> $stable(evt_count[0]))
		else $error("count moved in single mode");
	a_bus_answer: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		(AVS_READ_I || AVS_WRITE_I) |-> ##[0:1] !AVS_WAITREQUEST_O)
		else $error("bus answer late");
	a_status_enable_two: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		status_word[CH2_BASE] == probe_control_object[CH2_BASE])
		else $error("channel two enable mismatch");
	a_status_spare_zero: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		status_word[5:3] == 3'b000 && status_word[13:11] == 3'b000)
		else $error("spare status bits set");
	a_control_spare_zero: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		(probe_control_object & ~CONTROL_MASK) == 16'h0000)
		else $error("spare control bits set");
	a_rise_two_held: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		rise_take[1] |=> status_word[CH2_BASE + S_RISE_HELD])
		else $error("channel two rise flag not set");
	a_fall_two_held: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		fall_take[1] |=> status_word[CH2_BASE + S_FALL_HELD])
		else $error("channel two fall flag not set");
	a_fall_pos_stored: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		fall_take[1] |=> fall_pos[1] == $past(POSITION_I))
		else $error("fall position not stored");
	a_rise_pos_two: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		rise_take[1] |=> rise_pos[1] == $past(POSITION_I))
		else $error("channel two rise position not stored");
	a_fall_counter_step: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		fall_take[0] |=> fall_cnt[0] == $past(fall_cnt[0]) + 16'h0001)
		else $error("fall counter did not step");
	a_rise_edge_off: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		!cfg[0].rise_en |=> $stable(rise_pos[0]) && $stable(rise_cnt[0]))
		else $error("rise latched while off");
	a_fall_edge_off: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		!cfg[1].fall_en |=> $stable(fall_pos[1]) && $stable(fall_cnt[1]))
		else $error("fall latched while off");
	a_disabled_quiet: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		!cfg[0].enable |=> $stable(rise_cnt[0]) && $stable(fall_cnt[0]))
		else $error("disabled channel latched");
	a_count_one_step: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		cfg[0].mode && !rearm[0] && (rise_take[0] || fall_take[0]) |=>
		status_word[S_COUNT +: 2] == $past(status_word[S_COUNT +: 2]) + 2'h1)
		else $error("channel one count did not step");
	a_count_two_step: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		cfg[1].mode && !rearm[1] && (rise_take[1] || fall_take[1]) |=>
		evt_count[1] == $past(evt_count[1]) + 2'h1)
		else $error("channel two count did not step");
	a_sel_locked_two: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		sel_lock1 && $past(sel_lock1) |-> $stable(di_sel[1]))
		else $error("channel two input selection changed");
	a_index_abs_zero: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		cfg[0].source && ABS_ENCODER_I && TURN_POSITION_I == '0 |-> trig[0])
		else $error("index not at single-turn zero");
	a_wait_one_cycle: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("waitrequest low too long");
	a_read_clears_irq: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		rd_irq && irq_ev == 4'h0 |=> irq_stat == 4'h0)
		else $error("interrupt status not cleared");
	a_irq_masked_off: assert property (@(posedge CLOCK_I)
		disable iff (SYS_RST_I)
		irq_mask == 4'h0 |=> !IRQ_O)
		else $error("masked interrupt raised");
	c_rise_latch: cover property (@(posedge CLOCK_I) rise_take[0]);
	c_cont_count: cover property (@(posedge CLOCK_I) evt_count[1] == 2'h3);
	c_irq: cover property (@(posedge CLOCK_I) IRQ_O);
	c_fall_latch: cover property (@(posedge CLOCK_I) fall_take[1]);
	c_sel_refused: cover property (@(posedge CLOCK_I) wr_sel && sel_lock0);

endmodule : dual_touch_probe_latch

// ### dv/host_model.sv
`timescale 1ns/1ns

// ==========================================================
// host side: one word at a time over Avalon-MM
module host_model (
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	input wire logic wait_i,
	output logic [15:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [31:0] wdata_o,
	output logic [3:0] be_o
);
	initial begin
		addr_o = 16'h0000;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 32'h0000_0000;
		be_o = 4'h0;
	end

	task xfer(input logic rd, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q);
		addr_o <= a;
		rd_o <= rd;
		wr_o <= !rd;
		wdata_o <= d;
		be_o <= 4'hF;
		@(posedge clk_i);
		while (wait_i !== 1'b0) begin
			@(posedge clk_i);
		end
		q = rdata_i;
		rd_o <= 1'b0;
		wr_o <= 1'b0;
		// released lines must not keep the old value
		addr_o <= ~a;
		wdata_o <= ~d;
		be_o <= 4'h0;
		@(posedge clk_i);
	endtask : xfer
endmodule : host_model

// ### dv/test_dual_touch_probe_latch.sv
`timescale 1ns/1ns

module test_dual_touch_probe_latch;
	import probe_latch_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] addr;
	logic rd;
	logic wr;
	logic [31:0] wdata;
	logic [3:0] be;
	logic [31:0] rdata;
	logic waitr;
	logic [4:0] di = 5'h00;
	logic abs_enc = 1'b0;
	logic idx = 1'b0;
	logic [25:0] turn = 26'h0000005;
	logic signed [31:0] pos = 32'h0000_0000;
	logic irq;
	int err_count = 0;
	int n_checks = 0;

	typedef struct packed {
		logic [15:0] ctl;
		logic [15:0] ctl_rb;
		logic [15:0] stat;
	} row_t;
	row_t rows [4] = '{'{16'hFFFF, 16'h3737, 16'h0101},
		'{16'h0001, 16'h0001, 16'h0001}, '{16'h0100, 16'h0100, 16'h0100},
		'{16'h0000, 16'h0000, 16'h0000}};

	always #50 clk = ~clk;

	dual_touch_probe_latch dut (
		.CLOCK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
		.AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(waitr), .DIGITAL_INPUT_LINE_I(di),
		.ABS_ENCODER_I(abs_enc), .INDEX_PULSE_I(idx),
		.TURN_POSITION_I(turn), .POSITION_I(pos), .IRQ_O(irq));

	host_model host (
		.clk_i(clk), .rdata_i(rdata), .wait_i(waitr), .addr_o(addr),
		.rd_o(rd), .wr_o(wr), .wdata_o(wdata), .be_o(be));

	// ==========================================================
	// checks and bus helpers
	task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk32

	task chk1(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1

	task wreg(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		host.xfer(1'b0, a, d, q);
	endtask : wreg

	task rreg(input logic [15:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		host.xfer(1'b1, a, 32'h0000_0000, q);
		chk32(nm, e, q);
	endtask : rreg

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task finish_test;
		if (err_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	// ==========================================================
	// main sequence
	initial begin
		tick(6);
		rst <= 1'b0;
		tick(1);
		rreg(STATUS_OFS, 32'h0, "status");
		rreg(CONTROL_OFS, 32'h0, "control");
		foreach (rows[i]) begin
			wreg(CONTROL_OFS, {16'h0000, rows[i].ctl});
			rreg(CONTROL_OFS, {16'h0000, rows[i].ctl_rb}, "control");
			rreg(STATUS_OFS, {16'h0000, rows[i].stat}, "status");
		end
		wreg(STATUS_OFS, 32'hFFFF);
		rreg(STATUS_OFS, 32'h0, "status");
		// single capture from input line 2
		wreg(DI_SEL_OFS, 32'h2);
		wreg(CONTROL_OFS, 32'h31);
		wreg(DI_SEL_OFS, 32'h3);
		rreg(DI_SEL_OFS, 32'h2, "input select");
		pos <= 32'h1234_5678;
		di[2] <= 1'b1;
		tick(3);
		rreg(STATUS_OFS, 32'h3, "status");
		rreg(C1_RISE_POS_OFS, 32'h1234_5678, "rise pos");
		pos <= 32'hFFFF_FF00;
		di[2] <= 1'b0;
		tick(3);
		rreg(STATUS_OFS, 32'h7, "status");
		rreg(C1_FALL_POS_OFS, 32'hFFFF_FF00, "fall pos");
		rreg(C1_FALL_CNT_OFS, 32'h1, "fall count");
		pos <= 32'h0000_0055;
		di[2] <= 1'b1;
		tick(3);
		rreg(C1_RISE_POS_OFS, 32'h1234_5678, "rise pos");
		rreg(C1_RISE_CNT_OFS, 32'h1, "rise count");
		chk1("irq", 1'b0, irq);
		rreg(IRQ_STAT_OFS, 32'h3, "irq status");
		rreg(IRQ_STAT_OFS, 32'h0, "irq status");
		// re-arm on single-turn zero
		wreg(CONTROL_OFS, 32'h0);
		abs_enc <= 1'b1;
		wreg(CONTROL_OFS, 32'h15);
		rreg(STATUS_OFS, 32'h1, "status");
		pos <= 32'h0000_0777;
		turn <= 26'h0000000;
		tick(3);
		rreg(STATUS_OFS, 32'h3, "status");
		rreg(C1_RISE_POS_OFS, 32'h777, "rise pos");
		rreg(C1_RISE_CNT_OFS, 32'h2, "rise count");
		// continuous index capture on channel two
		turn <= 26'h0000005;
		wreg(IRQ_MASK_OFS, 32'h4);
		abs_enc <= 1'b0;
		wreg(CONTROL_OFS, 32'h3700);
		repeat (3) begin
			idx <= ~idx;
			tick(2);
		end
		tick(2);
		chk1("irq", 1'b1, irq);
		rreg(STATUS_OFS, 32'hC702, "status");
		rreg(C2_RISE_CNT_OFS, 32'h2, "rise count");
		rreg(C2_FALL_POS_OFS, 32'h777, "fall pos");
		rreg(C2_RISE_POS_OFS, 32'h777, "rise pos");
		rreg(C2_FALL_CNT_OFS, 32'h1, "fall count");
		rreg(IRQ_STAT_OFS, 32'hD, "irq status");
		tick(2);
		chk1("irq", 1'b0, irq);
		// continuous count on channel one wraps past three
		wreg(CONTROL_OFS, 32'h13);
		repeat (5) begin
			di[2] <= 1'b0;
			tick(2);
			di[2] <= 1'b1;
			tick(2);
		end
		rreg(STATUS_OFS, 32'hC643, "status");
		rreg(C1_RISE_CNT_OFS, 32'h7, "rise count");
		// locked byte refused, free byte taken
		wreg(DI_SEL_OFS, 32'h0304);
		wreg(IRQ_MASK_OFS, 32'h1);
		rreg(DI_SEL_OFS, 32'h0302, "input select");
		chk1("irq", 1'b1, irq);
		// reset in mid-run
		rst <= 1'b1;
		tick(2);
		chk1("waitrequest", 1'b1, waitr);
		chk1("irq", 1'b0, irq);
		rst <= 1'b0;
		tick(1);
		rreg(STATUS_OFS, 32'h0, "status");
		rreg(C1_RISE_POS_OFS, 32'h0, "rise pos");
		rreg(C1_RISE_CNT_OFS, 32'h0, "rise count");
		rreg(DI_SEL_OFS, 32'h0, "input select");
		finish_test;
	end

	initial begin
		tick(5000);
		err_count++;
		finish_test;
	end
endmodule : test_dual_touch_probe_latch
